// ---- health_cfg.svh ----
// Purpose: Constants for the health word monitor: bit positions, reset values, timing.
// Assumes: Included by bare name; definitions only.
// Notes:   Times are kept in their own units; cycle counts derive from them.
`ifndef HEALTH_CFG_SVH
`define HEALTH_CFG_SVH

`define CLK_HZ        100000000
`define UPDATE_HZ     200
`define INIT_TIME_S   60

`define BIT_FATAL     0
`define BIT_HW_FAULT  1
`define BIT_LINK_FAULT 2
`define BIT_SW_FAULT  3
`define BIT_SUMMARY   8
`define BIT_HW_ALERT  9
`define BIT_LINK_ALERT 10
`define BIT_SW_ALERT  11
`define BIT_OVR_ALERT 12

`define EN_HW         0
`define EN_LINK       1
`define EN_SW         2
`define EN_OVR        3
`define ALERT_EN_RST  4'h8
`define HEALTH_RST    16'h0000

`define RATE_LIMIT    16'h7000
`define YAW_SHIFT     3
`define RATE_QUIET    3'h7

`define DIV_100HZ     7'h02
`define DIV_50HZ      7'h04
`define DIV_25HZ      7'h08
`define DIV_20HZ      7'h0a
`define DIV_10HZ      7'h14
`define DIV_5HZ       7'h28
`define DIV_2HZ       7'h64

`endif

// ---- health_pkg.sv ----
// Purpose: Types shared by the health word monitor, its assertions, the host model and the bench.
// Assumes: Nothing is imported; users write health_pkg::name.
// Notes:   Packet struct carries both measurement and diagnostic content.
package health_pkg;

  typedef logic signed [15:0] rate_t;

  typedef enum logic {PKT_MEAS, PKT_DIAG} pkt_kind_e;

  typedef enum logic [1:0] {GAIN_INIT, GAIN_RUN, GAIN_COAST} gain_e;

  typedef struct packed {
    logic fatal;
    logic hw;
    logic link;
    logic sw;
  } fault_s;

  typedef struct packed {
    logic initActive;
    logic turnCoast;
  } sw_state_s;

  typedef struct packed {
    pkt_kind_e  kind;
    logic [15:0] health;
    rate_t      yawRate;
    sw_state_s  swState;
    fault_s     faults;
    logic [3:0] alertEn;
    gain_e      gain;
    logic       overRange;
  } packet_s;

endpackage

// ---- two_entry_buffer.sv ----
// Purpose: Two-entry buffer with valid/ready on both sides.
// Assumes: Same clock on both sides.
// Notes:   Output data come straight from the head register.
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output var  logic         inReady,
  output var  logic         outValid,
  output var  logic [W-1:0] outData,
  input  wire logic         outReady
);

  logic [W-1:0] tail;
  logic         tailValid;
  logic         push;
  logic         pop;

  assign inReady = ~tailValid;
  assign push    = inValid & ~tailValid;
  assign pop     = outValid & outReady;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outValid  <= 1'b0;
      tailValid <= 1'b0;
    end else if (pop) begin
      outValid  <= tailValid | push;
      tailValid <= tailValid & push;
    end else if (push) begin
      outValid  <= 1'b1;
      tailValid <= outValid;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outData <= '0;
      tail    <= '0;
    end else begin
      if (pop && tailValid) begin
        outData <= tail;
      end else if (push && (pop || !outValid)) begin
        outData <= inData;
      end
      if (push && ((outValid && !pop) || (pop && tailValid))) begin
        tail <= inData;
      end
    end
  end

endmodule // two_entry_buffer

`default_nettype wire

// ---- health_status_word_monitor.sv ----
// Purpose: Builds the 16-bit health word and emits measurement and diagnostic packets.
// Assumes: Fault levels, samples and commands come from logic on clk.
// Notes:   Packets leave through a two-entry buffer; a stalled host holds them back.
// Function
// - Every measurement packet carries the current two-byte health word.
// - Low byte holds error flags, high byte holds programmable alert flags.
// - Bit 0 reads 1 once a fatal error has occurred.
// - Bit 1 follows the internal hardware fault.
// - Bit 2 follows the communication fault.
// - Bit 3 follows the internal software fault; bits 4 to 7 reserved.
// - Bit 8 is the OR of all enabled alert bits.
// - Separate enables for alert bits 9 to 12; hardware, link, software off by default.
// - Bit 12 flags rate over-range and is enabled by default.
// - Only angular rate sensors can raise over-range, never accelerometers.
// - Measurement and attitude data refresh at a fixed 200 Hz.
// - Packets go out periodically at 100 to 2 Hz, or only on request.
// - A request naming the diagnostic packet returns full subsystem status.
// - Filtered yaw rate above threshold lowers accelerometer feedback gain once initialization is over.
// - Turn-coast flag stands in software alert status while threshold is exceeded.
// - Roughly 60 s initialization with heavy accelerometer weighting after start.
// - Software alert status shows that initialization is in progress.
// - Restart command resets the algorithm and re-enters initialization.
`timescale 1ns/1ps
`default_nettype none
`include "health_cfg.svh"

module health_status_word_monitor #(
  parameter int TICK_CYCLES = `CLK_HZ / `UPDATE_HZ,
  parameter int INIT_TICKS  = `INIT_TIME_S * `UPDATE_HZ
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 fatalFault,
  input  wire logic                 hwFault,
  input  wire logic                 linkFault,
  input  wire logic                 swFault,
  input  wire logic                 sampleValid,
  input  wire health_pkg::rate_t    rateSample [3],
  input  wire health_pkg::rate_t    turnThreshold,
  input  wire logic                 cfgWrite,
  input  wire logic [3:0]           cfgAlertEn,
  input  wire logic [2:0]           rateSel,
  input  wire logic                 fetchPacketCmd,
  input  wire logic                 fetchDiag,
  input  wire logic                 algoRestartCmd,
  output var  logic                 pktValid,
  output var  health_pkg::packet_s  pktData,
  input  wire logic                 pktReady,
  output var  logic [15:0]          builtInTestWord,
  output var  health_pkg::gain_e    gain,
  output var  logic                 algoResetPulse,
  output var  logic                 turnCoastFlag,
  output var  logic                 initActive
);

  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam int INIT_W = $clog2(INIT_TICKS + 1);

  // Update tick and refresh strobe
  logic [TICK_W-1:0] tickCount;
  logic              tick;
  logic              refresh;

  // Error flags
  logic              fatalFailFlag;
  logic              hwFaultFlag;
  logic              linkFaultFlag;
  logic              swFaultFlag;

  // Over-range tracking
  logic [2:0]        axisOver;
  logic              anyOver;
  logic              overSeen;
  logic              overRangeFlag;

  // Yaw filter
  health_pkg::rate_t yawFilt;
  logic signed [16:0] yawDiff;
  logic signed [16:0] yawStep;
  logic signed [16:0] next_yawFilt;
  logic [15:0]       yawMag;

  // Initialization phase
  logic [INIT_W-1:0] initCount;

  // Alerts and configuration
  logic [3:0]        alertEn;
  logic              hwAlertFlag;
  logic              linkAlertFlag;
  logic              swAlertFlag;
  logic              overrangeAlertFlag;
  logic              summaryAlertFlag;
  logic [15:0]       next_health;

  // Packet scheduling
  logic [6:0]        pktDiv;
  logic [6:0]        divLimit;
  logic              pktDue;
  logic              measPend;
  logic              diagPend;
  logic              bufInValid;
  logic              bufInReady;
  logic              pushed;
  health_pkg::packet_s bufInData;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCount <= '0;
      tick      <= 1'b0;
    end else if (tickCount == TICK_W'(TICK_CYCLES - 1)) begin
      tickCount <= '0;
      tick      <= 1'b1;
    end else begin
      tickCount <= tickCount + 1'b1;
      tick      <= 1'b0;
    end
  end

  // Health word is taken one cycle after the tick so flags updated on it are seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh <= 1'b0;
    end else begin
      refresh <= tick;
    end
  end

  // Fatal stays set until reset; the rest follow their sources
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fatalFailFlag <= 1'b0;
    end else if (fatalFault) begin
      fatalFailFlag <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hwFaultFlag   <= 1'b0;
      linkFaultFlag <= 1'b0;
      swFaultFlag   <= 1'b0;
    end else begin
      hwFaultFlag   <= hwFault;
      linkFaultFlag <= linkFault;
      swFaultFlag   <= swFault;
    end
  end

  // Only the rate axes feed this; accelerometers have no path in
  for (genvar i = 0; i < 3; i++) begin : g_axis
    logic [15:0] mag;
    assign mag         = rateSample[i][15] ? 16'(-rateSample[i]) : rateSample[i];
    assign axisOver[i] = mag >= `RATE_LIMIT;
  end

  assign anyOver = sampleValid & (|axisOver);

  // A sample that is over range in the tick cycle is never lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overSeen <= 1'b0;
    end else if (anyOver) begin
      overSeen <= 1'b1;
    end else if (tick) begin
      overSeen <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overRangeFlag <= 1'b0;
    end else if (tick) begin
      overRangeFlag <= overSeen | anyOver;
    end
  end

  // First-order low-pass on yaw; shift sets the corner
  assign yawDiff      = {rateSample[2][15], rateSample[2]} - {yawFilt[15], yawFilt};
  assign yawStep      = yawDiff >>> `YAW_SHIFT;
  assign next_yawFilt = {yawFilt[15], yawFilt} + yawStep;
  assign yawMag       = yawFilt[15] ? 16'(-yawFilt) : yawFilt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      yawFilt <= '0;
    end else if (algoRestartCmd) begin
      yawFilt <= '0;
    end else if (sampleValid) begin
      yawFilt <= 16'(next_yawFilt);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      turnCoastFlag <= 1'b0;
    end else if (algoRestartCmd) begin
      turnCoastFlag <= 1'b0;
    end else if (tick) begin
      turnCoastFlag <= yawMag > 16'(turnThreshold);
    end
  end

  // Restart takes priority over the phase count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      initActive <= 1'b1;
      initCount  <= '0;
    end else if (algoRestartCmd) begin
      initActive <= 1'b1;
      initCount  <= '0;
    end else if (tick && initActive) begin
      if (initCount == INIT_W'(INIT_TICKS - 1)) begin
        initActive <= 1'b0;
      end else begin
        initCount <= initCount + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      algoResetPulse <= 1'b0;
    end else begin
      algoResetPulse <= algoRestartCmd;
    end
  end

  // Heavy weighting while initializing, coast through turns afterwards
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain <= health_pkg::GAIN_INIT;
    end else if (initActive) begin
      gain <= health_pkg::GAIN_INIT;
    end else if (turnCoastFlag) begin
      gain <= health_pkg::GAIN_COAST;
    end else begin
      gain <= health_pkg::GAIN_RUN;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alertEn <= `ALERT_EN_RST;
    end else if (cfgWrite) begin
      alertEn <= cfgAlertEn;
    end
  end

  assign hwAlertFlag        = alertEn[`EN_HW] & hwFaultFlag;
  assign linkAlertFlag      = alertEn[`EN_LINK] & linkFaultFlag;
  assign swAlertFlag        = alertEn[`EN_SW] & (swFaultFlag | initActive | turnCoastFlag);
  assign overrangeAlertFlag = alertEn[`EN_OVR] & overRangeFlag;
  assign summaryAlertFlag   = hwAlertFlag | linkAlertFlag | swAlertFlag | overrangeAlertFlag;

  always_comb begin
    next_health                  = `HEALTH_RST;
    next_health[`BIT_FATAL]      = fatalFailFlag;
    next_health[`BIT_HW_FAULT]   = hwFaultFlag;
    next_health[`BIT_LINK_FAULT] = linkFaultFlag;
    next_health[`BIT_SW_FAULT]   = swFaultFlag;
    next_health[`BIT_SUMMARY]    = summaryAlertFlag;
    next_health[`BIT_HW_ALERT]   = hwAlertFlag;
    next_health[`BIT_LINK_ALERT] = linkAlertFlag;
    next_health[`BIT_SW_ALERT]   = swAlertFlag;
    next_health[`BIT_OVR_ALERT]  = overrangeAlertFlag;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      builtInTestWord <= `HEALTH_RST;
    end else if (refresh) begin
      builtInTestWord <= next_health;
    end
  end

  // Quiet leaves the divider idle; packets then come only on request
  always_comb begin
    unique case (rateSel)
      3'h0:    divLimit = `DIV_100HZ;
      3'h1:    divLimit = `DIV_50HZ;
      3'h2:    divLimit = `DIV_25HZ;
      3'h3:    divLimit = `DIV_20HZ;
      3'h4:    divLimit = `DIV_10HZ;
      3'h5:    divLimit = `DIV_5HZ;
      3'h6:    divLimit = `DIV_2HZ;
      default: divLimit = `DIV_2HZ;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pktDiv <= '0;
      pktDue <= 1'b0;
    end else if (refresh && rateSel != `RATE_QUIET) begin
      if (pktDiv >= divLimit - 7'h01) begin
        pktDiv <= '0;
        pktDue <= 1'b1;
      end else begin
        pktDiv <= pktDiv + 7'h01;
        pktDue <= 1'b0;
      end
    end else begin
      pktDue <= 1'b0;
      if (rateSel == `RATE_QUIET) begin
        pktDiv <= '0;
      end
    end
  end

  // Diagnostic goes first; a new request in the push cycle wins over the clear
  assign bufInValid = measPend | diagPend;
  assign pushed     = bufInValid & bufInReady;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      measPend <= 1'b0;
    end else if (pktDue || (fetchPacketCmd && !fetchDiag)) begin
      measPend <= 1'b1;
    end else if (pushed && !diagPend) begin
      measPend <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diagPend <= 1'b0;
    end else if (fetchPacketCmd && fetchDiag) begin
      diagPend <= 1'b1;
    end else if (pushed) begin
      diagPend <= 1'b0;
    end
  end

  // Measurement packets carry the health word; diagnostic adds all status
  always_comb begin
    bufInData            = '0;
    bufInData.kind       = diagPend ? health_pkg::PKT_DIAG : health_pkg::PKT_MEAS;
    bufInData.health     = builtInTestWord;
    bufInData.yawRate    = yawFilt;
    bufInData.swState    = '{initActive: initActive, turnCoast: turnCoastFlag};
    if (diagPend) begin
      bufInData.faults    = '{fatal: fatalFailFlag, hw: hwFaultFlag, link: linkFaultFlag, sw: swFaultFlag};
      bufInData.alertEn   = alertEn;
      bufInData.gain      = gain;
      bufInData.overRange = overRangeFlag;
    end
  end

  two_entry_buffer #(
    .W($bits(health_pkg::packet_s))
  ) u_pkt_buffer (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (bufInValid),
    .inData   (bufInData),
    .inReady  (bufInReady),
    .outValid (pktValid),
    .outData  (pktData),
    .outReady (pktReady)
  );

endmodule // health_status_word_monitor

`default_nettype wire

// ---- health_status_word_monitor_props.sv ----
// Purpose: Port assertions for the health word monitor.
// Assumes: Bound into every monitor instance; one clock domain.
// Notes:   Gain choice while init and coast overlap is left open.
`timescale 1ns/1ps
`default_nettype none

module health_status_word_monitor_props #(
  parameter int TICK_CYCLES = 10,
  parameter int INIT_TICKS  = 5
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                fetchPacketCmd,
  input wire logic                algoRestartCmd,
  input wire logic                pktValid,
  input wire health_pkg::packet_s pktData,
  input wire logic                pktReady,
  input wire logic [15:0]         builtInTestWord,
  input wire health_pkg::gain_e   gain,
  input wire logic                algoResetPulse,
  input wire logic                turnCoastFlag,
  input wire logic                initActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_fatal_sticky: assert property (builtInTestWord[0] |=> builtInTestWord[0])
    else $error("fatal bit dropped");
  chk_reserved_zero: assert property (builtInTestWord[7:4] == 4'h0 && builtInTestWord[15:13] == 3'h0)
    else $error("reserved bit set");
  chk_summary_or: assert property (builtInTestWord[8] == |builtInTestWord[12:9])
    else $error("summary alert wrong");
  chk_alert_source: assert property ((!builtInTestWord[9] || builtInTestWord[1]) &&
    (!builtInTestWord[10] || builtInTestWord[2])) else $error("alert without fault");
  chk_stall_hold: assert property (pktValid && !pktReady |=> pktValid && $stable(pktData))
    else $error("packet changed while stalled");
  chk_fetch_answer: assert property (fetchPacketCmd && !pktValid |-> ##[1:3] pktValid)
    else $error("request not answered");
  chk_meas_fields: assert property (pktValid && pktData.kind == health_pkg::PKT_MEAS |->
    pktData.faults == 4'h0 && pktData.alertEn == 4'h0 && !pktData.overRange) else $error("meas fields set");
  chk_restart_init: assert property (algoRestartCmd |=> initActive && algoResetPulse && !turnCoastFlag)
    else $error("restart not taken");
  chk_gain_coast: assert property ((turnCoastFlag && !initActive)[*2] |-> gain == health_pkg::GAIN_COAST)
    else $error("gain not coast");
  chk_gain_run: assert property ((!turnCoastFlag && !initActive)[*2] |-> gain == health_pkg::GAIN_RUN)
    else $error("gain not run");
  chk_gain_init: assert property ((initActive && !turnCoastFlag)[*2] |-> gain == health_pkg::GAIN_INIT)
    else $error("gain not init");
endmodule // health_status_word_monitor_props

bind health_status_word_monitor health_status_word_monitor_props #(
  .TICK_CYCLES(TICK_CYCLES),
  .INIT_TICKS (INIT_TICKS)
) i_health_status_word_monitor_props (
  .clk, .rst_n, .fetchPacketCmd, .algoRestartCmd, .pktValid, .pktData, .pktReady,
  .builtInTestWord, .gain, .algoResetPulse, .turnCoastFlag, .initActive
);

`default_nettype wire

// ---- host_sink_model.sv ----
// Purpose: Host side that takes packets from the monitor.
// Assumes: Bench raises stall to hold packets back.
// Notes:   Keeps only the last packet and a count.
`timescale 1ns/1ps
`default_nettype none

module host_sink_model (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                stall,
  input  wire logic                pktValid,
  input  wire health_pkg::packet_s pktData,
  output var  logic                pktReady,
  output var  health_pkg::packet_s lastPkt,
  output var  logic [15:0]         rxCount
);
  assign pktReady = !stall;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxCount <= 16'h0000;
      lastPkt <= '0;
    end else if (pktValid && pktReady) begin
      rxCount <= rxCount + 16'h0001;
      lastPkt <= pktData;
    end
  end
endmodule // host_sink_model

`default_nettype wire

// ---- health_status_word_monitor_bench.sv ----
// Purpose: Self-checking bench for the health word monitor.
// Assumes: Short tick and init counts; host model sinks packets.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none

module health_status_word_monitor_bench;
  localparam int TICK = 10;
  localparam logic [15:0] OVR [4] = '{16'h7000, 16'h6fff, 16'h9000, 16'h9001};
  localparam logic [15:0] OVR_EXP [4] = '{16'h1100, 16'h0000, 16'h1100, 16'h0000};
  localparam int DIV [7] = '{2, 4, 8, 10, 20, 40, 100};
  logic                clk, rst_n, fatalFault, hwFault, linkFault, swFault, sampleValid;
  logic                cfgWrite, fetchPacketCmd, fetchDiag, algoRestartCmd, stall;
  logic                pktValid, pktReady, algoResetPulse, turnCoastFlag, initActive;
  logic [3:0]          cfgAlertEn;
  logic [2:0]          rateSel;
  logic [15:0]         rxCount, builtInTestWord;
  health_pkg::rate_t   rateSample [3];
  health_pkg::rate_t   turnThreshold;
  health_pkg::packet_s pktData, lastPkt;
  health_pkg::gain_e   gain;
  int                  failures, totalChecks, n;

  health_status_word_monitor #(.TICK_CYCLES(TICK), .INIT_TICKS(5)) i_health_status_word_monitor (
    .clk, .rst_n, .fatalFault, .hwFault, .linkFault, .swFault, .sampleValid, .rateSample,
    .turnThreshold, .cfgWrite, .cfgAlertEn, .rateSel, .fetchPacketCmd, .fetchDiag, .algoRestartCmd,
    .pktValid, .pktData, .pktReady, .builtInTestWord, .gain, .algoResetPulse, .turnCoastFlag, .initActive
  );
  host_sink_model i_host_sink_model (.clk, .rst_n, .stall, .pktValid, .pktData, .pktReady, .lastPkt, .rxCount);

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic writeCfg(input logic [3:0] en);
    cfgAlertEn = en;
    cfgWrite = 1'b1;
    cyc(1);
    cfgWrite = 1'b0;
  endtask

  // Two and a half tick periods (25 cycles) cover the fault register and the refresh edge
  task automatic readWord(input logic [15:0] exp);
    cyc(25);
    check("builtInTestWord", builtInTestWord, exp);
  endtask

  task automatic fetch(input logic diag);
    fetchDiag = diag;
    fetchPacketCmd = 1'b1;
    cyc(1);
    fetchPacketCmd = 1'b0;
    cyc(1);
  endtask

  task automatic waitPkt(input int limit, output int k);
    logic [15:0] start;
    start = rxCount;
    for (k = 0; k < limit && rxCount === start; k++) cyc(1);
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up();
  end

  initial begin
    {fatalFault, hwFault, linkFault, swFault, sampleValid, cfgWrite} = '0;
    {fetchPacketCmd, fetchDiag, algoRestartCmd, stall, cfgAlertEn} = '0;
    rateSel = 3'h7;
    turnThreshold = 16'h7fff;
    rateSample = '{default: 16'h0000};
    rst_n = 1'b0;
    cyc(5);
    check("initActive", {15'h0, initActive}, 16'h0001);
    check("pktValid", {15'h0, pktValid}, 16'h0000);
    rst_n = 1'b1;
    readWord(16'h0000);
    cyc(60);
    check("initActive", {15'h0, initActive}, 16'h0000);
    check("gain", {14'h0, gain}, {14'h0, health_pkg::GAIN_RUN});
    sampleValid = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rateSample[1] = OVR[i];
      readWord(OVR_EXP[i]);
    end
    sampleValid = 1'b0;
    for (int c = 0; c < 2; c++) begin
      writeCfg(c ? 4'h0 : 4'hf);
      for (int k = 0; k < 3; k++) begin
        {hwFault, linkFault, swFault} = 3'b100 >> k;
        readWord((16'h0002 << k) | (c ? 16'h0000 : (16'h0200 << k) | 16'h0100));
      end
    end
    {hwFault, linkFault, swFault} = 3'b000;
    writeCfg(4'h8);
    cyc(250);
    check("rxCount", rxCount, 16'h0000);
    fetch(1'b1);
    waitPkt(20, n);
    check("kind", {15'h0, lastPkt.kind}, {15'h0, health_pkg::PKT_DIAG});
    check("alertEn", {12'h0, lastPkt.alertEn}, 16'h0008);
    fetch(1'b0);
    waitPkt(20, n);
    check("kind", {15'h0, lastPkt.kind}, {15'h0, health_pkg::PKT_MEAS});
    check("health", lastPkt.health, 16'h0000);
    stall = 1'b1;
    fetch(1'b0);
    fetch(1'b1);
    fetch(1'b0);
    cyc(20);
    check("rxCount", rxCount, 16'h0002);
    stall = 1'b0;
    cyc(10);
    check("rxCount", rxCount, 16'h0005);
    check("kind", {15'h0, lastPkt.kind}, {15'h0, health_pkg::PKT_MEAS});
    for (int s = 0; s < 7; s++) begin
      rateSel = 3'(s);
      waitPkt(1500, n);
      waitPkt(1500, n);
      check("period", 16'(n), 16'(DIV[s] * TICK));
    end
    rateSel = 3'h7;
    writeCfg(4'h4);
    turnThreshold = 16'h0100;
    rateSample[2] = 16'h4000;
    sampleValid = 1'b1;
    readWord(16'h0900);
    check("turnCoastFlag", {15'h0, turnCoastFlag}, 16'h0001);
    check("gain", {14'h0, gain}, {14'h0, health_pkg::GAIN_COAST});
    fetch(1'b1);
    waitPkt(20, n);
    check("swState", {14'h0, lastPkt.swState}, 16'h0001);
    check("diagGain", {14'h0, lastPkt.gain}, {14'h0, health_pkg::GAIN_COAST});
    sampleValid = 1'b0;
    algoRestartCmd = 1'b1;
    cyc(1);
    algoRestartCmd = 1'b0;
    check("algoResetPulse", {15'h0, algoResetPulse}, 16'h0001);
    readWord(16'h0900);
    check("turnCoastFlag", {15'h0, turnCoastFlag}, 16'h0000);
    fetch(1'b0);
    waitPkt(20, n);
    check("swState", {14'h0, lastPkt.swState}, 16'h0002);
    check("yawRate", lastPkt.yawRate, 16'h0000);
    cyc(40);
    readWord(16'h0000);
    fatalFault = 1'b1;
    cyc(1);
    fatalFault = 1'b0;
    readWord(16'h0001);
    readWord(16'h0001);
    rst_n = 1'b0;
    cyc(2);
    check("builtInTestWord", builtInTestWord, 16'h0000);
    rst_n = 1'b1;
    cyc(5);
    wrap_up();
  end
endmodule // health_status_word_monitor_bench

`default_nettype wire
